// [common/cp0h_pkg.sv]
package cp0h_pkg;
   typedef enum logic [2:0] {
      CP0H_OP_ALU, CP0H_OP_BRANCH, CP0H_OP_LDST, CP0H_OP_PROBE,
      CP0H_OP_EXCEPTION_RETURN, CP0H_OP_EXC, CP0H_OP_SHUT_I, CP0H_OP_SHUT_D
   } cp0h_op_e;
   typedef struct packed {
      cp0h_op_e op;
      logic [31:0] data;
   } cp0h_issue_s;
endpackage : cp0h_pkg

// [common/cp0h_regs.svh]
// Function
// - a config write that makes the kernel segment uncached takes effect from the third instruction fetched after it.
// - a jump or branch directly after the tlb shutdown flag is set makes the core stall for some slots.
// - a status write that changes the privilege field and sets the exception or error level may run two instructions in the new mode.
// - exception_return reads saved pc at its source stage, two slots after a write to it; status it takes from the newest write.
// - tlb_probe writes the index register late, so a read of it needs two slots of spacing.
// - exceptions make spacing undefined, so pending writes settle at once when one is taken.
// - a tlb shutdown writes the tlb_shutdown_flag, complete at the event destination stage.
// - coprocessor and tlb operations interlock only for a branch right after a tlb shutdown; spacing alone resolves the rest.
`ifndef CP0H_REGS_SVH
`define CP0H_REGS_SVH
// ==========================================
// offsets
`define CP0H_ADDR_STATUS 8'h00
`define CP0H_ADDR_CONFIG 8'h04
`define CP0H_ADDR_INDEX 8'h08
`define CP0H_ADDR_EPC 8'h0C
// ==========================================
// fields
`define CP0H_ST_IE 0
`define CP0H_ST_EXL 1
`define CP0H_ST_ERL 2
`define CP0H_ST_KSU_LO 3
`define CP0H_ST_KSU_HI 4
`define CP0H_ST_TS 8
`define CP0H_CFG_K0_LO 0
`define CP0H_CFG_K0_HI 2
`define CP0H_K0_UNCACHED 3'h2
// ==========================================
// reset values
`define CP0H_ST_RST 32'h00000004
`define CP0H_CFG_RST 32'h00000003
`define CP0H_ZERO_RST 32'h00000000
// ==========================================
// stage numbers and branch stall length
`define CP0H_D_MOVE 3'h5
`define CP0H_D_PROBE 3'h6
`define CP0H_D_RET 3'h4
`define CP0H_D_EXC 3'h4
`define CP0H_D_TS_I 3'h2
`define CP0H_D_TS_D 3'h4
`define CP0H_S_MFROM 3'h3
`define CP0H_S_FETCH 3'h2
`define CP0H_S_RET 3'h2
`define CP0H_S_INT 3'h2
`define CP0H_BR_STALL 4'h3
`endif

// [rtl/cp0h_hazard.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cp0h_regs.svh"
module cp0h_hazard (
   input wire logic sys_clk,
   input wire logic sys_ce,
   input wire logic resetn,
   input wire logic issue_valid,
   input wire cp0h_pkg::cp0h_issue_s issue,
   output logic issue_ready,
   input wire logic int_req,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic fetch_uncached,
   output logic fetch_kernel,
   output logic int_take,
   output logic ret_valid,
   output logic [31:0] ret_pc
);
   // ==========================================
   // visibility: consumer sees the new value once enough slots passed
   function automatic logic vis(input logic pend, input logic [2:0] age, input logic [2:0] dst,
                                input logic [2:0] src);
      vis = !pend || (age >= 3'(dst - src - 3'h1));
   endfunction : vis

   logic accept, slot, is_br, is_ret, is_exc, is_probe, is_shut;
   logic st_load, epc_load, cfg_load, idx_load, ts_load, flush;
   logic [31:0] st_val, epc_val;
   logic [2:0] st_dst, epc_dst, idx_dst, ts_dst_in;
   logic ts_val;
   logic [31:0] st_arch, st_new, epc_arch, epc_new, cfg_arch, cfg_new, idx_arch, idx_new;
   logic [2:0] st_age, epc_age, cfg_age, idx_age, ts_age, st_dstq, epc_dstq, cfg_dstq, idx_dstq, ts_dstq;
   logic st_pend, epc_pend, cfg_pend, idx_pend, ts_pend, ts_arch, ts_new;
   logic [31:0] st_cur, st_fetch, st_int;
   logic rq4_case;
   logic [1:0] ksu_fetch;
   logic [3:0] stall_cnt_ff, nxt_stall_cnt;

   // bus strobes take the slot; only the stall of a branch right after a shutdown holds the issue port
   assign issue_ready = (stall_cnt_ff == 4'h0) && !reg_wr && !reg_rd;
   assign accept = issue_valid && issue_ready;
   assign slot = accept || reg_wr || reg_rd;
   assign is_br = accept && (issue.op == cp0h_pkg::CP0H_OP_BRANCH);
   assign is_ret = accept && (issue.op == cp0h_pkg::CP0H_OP_EXCEPTION_RETURN);
   assign is_exc = accept && (issue.op == cp0h_pkg::CP0H_OP_EXC);
   assign is_probe = accept && (issue.op == cp0h_pkg::CP0H_OP_PROBE);
   assign is_shut = accept && ((issue.op == cp0h_pkg::CP0H_OP_SHUT_I) || (issue.op == cp0h_pkg::CP0H_OP_SHUT_D));
   assign flush = is_exc;

   // ==========================================
   // load selection
   always_comb begin
      st_cur = st_pend ? st_new : st_arch;
      st_load = 1'b0;
      st_val = st_cur;
      st_dst = `CP0H_D_MOVE;
      if (reg_wr && (reg_addr == `CP0H_ADDR_STATUS)) begin
         st_load = 1'b1;
         st_val = reg_wdata;
         st_val[`CP0H_ST_TS] = 1'b0;
      end else if (is_exc) begin
         st_load = 1'b1;
         st_val[`CP0H_ST_EXL] = 1'b1;
         st_dst = `CP0H_D_EXC;
      end else if (is_ret) begin
         st_load = 1'b1;
         st_val[`CP0H_ST_EXL] = 1'b0;
         st_val[`CP0H_ST_ERL] = 1'b0;
         st_dst = `CP0H_D_RET;
      end
      epc_load = (reg_wr && (reg_addr == `CP0H_ADDR_EPC)) || is_exc;
      epc_val = is_exc ? issue.data : reg_wdata;
      epc_dst = is_exc ? `CP0H_D_EXC : `CP0H_D_MOVE;
      cfg_load = reg_wr && (reg_addr == `CP0H_ADDR_CONFIG);
      idx_load = (reg_wr && (reg_addr == `CP0H_ADDR_INDEX)) || is_probe;
      idx_dst = is_probe ? `CP0H_D_PROBE : `CP0H_D_MOVE;
      ts_load = is_shut || (reg_wr && (reg_addr == `CP0H_ADDR_STATUS));
      ts_val = is_shut ? 1'b1 : reg_wdata[`CP0H_ST_TS];
      ts_dst_in = `CP0H_D_MOVE;
      if (is_shut) ts_dst_in = (issue.op == cp0h_pkg::CP0H_OP_SHUT_I) ? `CP0H_D_TS_I : `CP0H_D_TS_D;
   end

   cp0h_pend #(.W(32), .RST(`CP0H_ST_RST)) u_status (
      .sys_clk(sys_clk), .resetn(resetn), .sys_ce(sys_ce), .step(slot), .flush(flush),
      .load(st_load), .load_val(st_val), .load_dst(st_dst),
      .arch_ff(st_arch), .new_ff(st_new), .age_ff(st_age), .dst_ff(st_dstq), .pend_ff(st_pend));
   cp0h_pend #(.W(32), .RST(`CP0H_ZERO_RST)) u_epc (
      .sys_clk(sys_clk), .resetn(resetn), .sys_ce(sys_ce), .step(slot), .flush(flush),
      .load(epc_load), .load_val(epc_val), .load_dst(epc_dst),
      .arch_ff(epc_arch), .new_ff(epc_new), .age_ff(epc_age), .dst_ff(epc_dstq), .pend_ff(epc_pend));
   cp0h_pend #(.W(32), .RST(`CP0H_CFG_RST)) u_config (
      .sys_clk(sys_clk), .resetn(resetn), .sys_ce(sys_ce), .step(slot), .flush(flush),
      .load(cfg_load), .load_val(reg_wdata), .load_dst(`CP0H_D_MOVE),
      .arch_ff(cfg_arch), .new_ff(cfg_new), .age_ff(cfg_age), .dst_ff(cfg_dstq), .pend_ff(cfg_pend));
   cp0h_pend #(.W(32), .RST(`CP0H_ZERO_RST)) u_index (
      .sys_clk(sys_clk), .resetn(resetn), .sys_ce(sys_ce), .step(slot), .flush(flush),
      .load(idx_load), .load_val(is_probe ? issue.data : reg_wdata), .load_dst(idx_dst),
      .arch_ff(idx_arch), .new_ff(idx_new), .age_ff(idx_age), .dst_ff(idx_dstq), .pend_ff(idx_pend));
   cp0h_pend #(.W(1), .RST(1'b0)) u_shutdown (
      .sys_clk(sys_clk), .resetn(resetn), .sys_ce(sys_ce), .step(slot), .flush(flush),
      .load(ts_load), .load_val(ts_val), .load_dst(ts_dst_in),
      .arch_ff(ts_arch), .new_ff(ts_new), .age_ff(ts_age), .dst_ff(ts_dstq), .pend_ff(ts_pend));

   // ==========================================
   // views seen by each consumer stage
   always_comb begin
      st_fetch = vis(st_pend, st_age, st_dstq, `CP0H_S_FETCH) ? st_cur : st_arch;
      st_int = vis(st_pend, st_age, st_dstq, `CP0H_S_INT) ? st_cur : st_arch;
      // new privilege leaks before the level bits land: a known window
      rq4_case = st_pend && (st_new[`CP0H_ST_EXL] || st_new[`CP0H_ST_ERL]) &&
                 (st_new[`CP0H_ST_KSU_HI:`CP0H_ST_KSU_LO] != st_arch[`CP0H_ST_KSU_HI:`CP0H_ST_KSU_LO]);
      ksu_fetch = rq4_case ? st_new[`CP0H_ST_KSU_HI:`CP0H_ST_KSU_LO] :
                  st_fetch[`CP0H_ST_KSU_HI:`CP0H_ST_KSU_LO];
   end

   // ==========================================
   // outputs and stall
   logic [31:0] rdata_ff, nxt_rdata, ret_pc_ff, nxt_ret_pc;
   logic fetch_unc_ff, nxt_fetch_unc, fetch_kern_ff, nxt_fetch_kern, int_take_ff, nxt_int_take;
   logic ret_valid_ff, nxt_ret_valid, last_shut_ff, nxt_last_shut;
   logic [31:0] cfg_fetch;
   always_comb begin
      nxt_rdata = 32'h00000000;
      nxt_ret_pc = ret_pc_ff;
      nxt_ret_valid = 1'b0;
      nxt_fetch_unc = fetch_unc_ff;
      nxt_fetch_kern = fetch_kern_ff;
      nxt_last_shut = last_shut_ff;
      nxt_stall_cnt = (stall_cnt_ff != 4'h0) ? 4'(stall_cnt_ff - 4'h1) : 4'h0;
      cfg_fetch = vis(cfg_pend, cfg_age, cfg_dstq, `CP0H_S_FETCH) ? (cfg_pend ? cfg_new : cfg_arch) : cfg_arch;
      nxt_int_take = int_req && st_int[`CP0H_ST_IE] && !st_int[`CP0H_ST_EXL] && !st_int[`CP0H_ST_ERL];
      if (reg_rd) begin
         case (reg_addr)
            `CP0H_ADDR_STATUS: begin
               nxt_rdata = vis(st_pend, st_age, st_dstq, `CP0H_S_MFROM) ? st_cur : st_arch;
               nxt_rdata[`CP0H_ST_TS] = vis(ts_pend, ts_age, ts_dstq, `CP0H_S_MFROM) && ts_pend ? ts_new : ts_arch;
            end
            `CP0H_ADDR_CONFIG: nxt_rdata = vis(cfg_pend, cfg_age, cfg_dstq, `CP0H_S_MFROM) && cfg_pend ? cfg_new : cfg_arch;
            `CP0H_ADDR_INDEX: nxt_rdata = vis(idx_pend, idx_age, idx_dstq, `CP0H_S_MFROM) && idx_pend ? idx_new : idx_arch;
            `CP0H_ADDR_EPC: nxt_rdata = vis(epc_pend, epc_age, epc_dstq, `CP0H_S_MFROM) && epc_pend ? epc_new : epc_arch;
            default: nxt_rdata = 32'h00000000;
         endcase
      end
      if (slot) begin
         nxt_fetch_unc = cfg_fetch[`CP0H_CFG_K0_HI:`CP0H_CFG_K0_LO] == `CP0H_K0_UNCACHED;
         nxt_fetch_kern = st_fetch[`CP0H_ST_EXL] || st_fetch[`CP0H_ST_ERL] || (ksu_fetch == 2'h0);
         nxt_last_shut = is_shut;
      end
      if (is_br && last_shut_ff) nxt_stall_cnt = `CP0H_BR_STALL;
      if (is_ret) begin
         nxt_ret_valid = 1'b1;
         nxt_ret_pc = vis(epc_pend, epc_age, epc_dstq, `CP0H_S_RET) && epc_pend ? epc_new : epc_arch;
      end
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_ff <= 32'h00000000;
         ret_pc_ff <= 32'h00000000;
         ret_valid_ff <= 1'b0;
         fetch_unc_ff <= 1'b0;
         fetch_kern_ff <= 1'b1;
         int_take_ff <= 1'b0;
         last_shut_ff <= 1'b0;
         stall_cnt_ff <= 4'h0;
      end else if (sys_ce) begin
         rdata_ff <= nxt_rdata;
         ret_pc_ff <= nxt_ret_pc;
         ret_valid_ff <= nxt_ret_valid;
         fetch_unc_ff <= nxt_fetch_unc;
         fetch_kern_ff <= nxt_fetch_kern;
         int_take_ff <= nxt_int_take;
         last_shut_ff <= nxt_last_shut;
         stall_cnt_ff <= nxt_stall_cnt;
      end
   end
   assign reg_rdata = rdata_ff;
   assign fetch_uncached = fetch_unc_ff;
   assign fetch_kernel = fetch_kern_ff;
   assign int_take = int_take_ff;
   assign ret_valid = ret_valid_ff;
   assign ret_pc = ret_pc_ff;

   // ==========================================
   // checks
   sequence s_br_after_shut;
      sys_ce && is_br && last_shut_ff;
   endsequence
   sequence s_held_off;
      !issue_ready [*3];
   endsequence
   a_uncached_third: assert property (@(posedge sys_clk) disable iff (!resetn)
      (sys_ce && slot && cfg_pend && cfg_age < 3'h2) |=>
      fetch_uncached == ($past(cfg_arch[`CP0H_CFG_K0_HI:`CP0H_CFG_K0_LO]) == `CP0H_K0_UNCACHED))
      else $error("kseg mode switched too early");
   a_branch_stall_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_br_after_shut |=> s_held_off) else $error("branch after shutdown did not stall");
   a_mode_window: assert property (@(posedge sys_clk) disable iff (!resetn)
      (sys_ce && slot && rq4_case && (st_new[`CP0H_ST_KSU_HI:`CP0H_ST_KSU_LO] != 2'h0) &&
       !vis(st_pend, st_age, st_dstq, `CP0H_S_FETCH) && !st_arch[`CP0H_ST_EXL] && !st_arch[`CP0H_ST_ERL])
      |=> !fetch_kernel) else $error("mode window not seen");
   a_ret_old_epc: assert property (@(posedge sys_clk) disable iff (!resetn)
      (sys_ce && is_ret && epc_pend && epc_dstq == 3'h5 && epc_age < 3'h2) |=> ret_valid && ret_pc == $past(epc_arch))
      else $error("return used unsettled saved pc");
   a_probe_late: assert property (@(posedge sys_clk) disable iff (!resetn)
      (sys_ce && reg_rd && reg_addr == `CP0H_ADDR_INDEX && idx_pend && idx_dstq == 3'h6 && idx_age < 3'h2)
      |=> reg_rdata == $past(idx_arch)) else $error("probe result visible too early");
   a_exc_settles: assert property (@(posedge sys_clk) disable iff (!resetn)
      (sys_ce && is_exc) |=> !cfg_pend && !idx_pend && !ts_pend) else $error("exception left writes pending");
   a_shut_inst_two: assert property (@(posedge sys_clk) disable iff (!resetn)
      (sys_ce && slot && !ts_load && !flush && ts_pend && ts_dstq == 3'h2 && ts_age == 3'h1)
      |=> ts_arch && !ts_pend) else $error("shutdown flag not written at stage");
   a_no_interlock: assert property (@(posedge sys_clk) disable iff (!resetn)
      (sys_ce && stall_cnt_ff == 4'h1) |=> (issue_ready || reg_wr || reg_rd)) else $error("hazard interlocked");
endmodule : cp0h_hazard
`default_nettype wire

// [rtl/cp0h_pend.sv]
`timescale 1ns/1ps
`default_nettype none
module cp0h_pend #(
   parameter int W = 32,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic sys_ce,
   input wire logic step,
   input wire logic flush,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic [2:0] load_dst,
   output logic [W-1:0] arch_ff,
   output logic [W-1:0] new_ff,
   output logic [2:0] age_ff,
   output logic [2:0] dst_ff,
   output logic pend_ff
);
   initial begin
      if (W < 1) $error("cp0h_pend: W must be positive");
   end
   logic [W-1:0] nxt_arch, nxt_new;
   logic [2:0] nxt_age, nxt_dst;
   logic nxt_pend;
   // ==========================================
   // pending write, ages one per issued slot
   always_comb begin
      nxt_arch = arch_ff;
      nxt_new = new_ff;
      nxt_age = age_ff;
      nxt_dst = dst_ff;
      nxt_pend = pend_ff;
      if (load) begin
         // older write retires first: a newer one replaces it
         if (pend_ff) nxt_arch = new_ff;
         nxt_new = load_val;
         nxt_age = 3'h0;
         nxt_dst = load_dst;
         nxt_pend = 1'b1;
      end else if (pend_ff && (flush || (step && (3'(age_ff + 3'h1) >= dst_ff)))) begin
         nxt_arch = new_ff;
         nxt_pend = 1'b0;
      end else if (pend_ff && step) begin
         nxt_age = 3'(age_ff + 3'h1);
      end
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         arch_ff <= RST;
         new_ff <= RST;
         age_ff <= 3'h0;
         dst_ff <= 3'h0;
         pend_ff <= 1'b0;
      end else if (sys_ce) begin
         arch_ff <= nxt_arch;
         new_ff <= nxt_new;
         age_ff <= nxt_age;
         dst_ff <= nxt_dst;
         pend_ff <= nxt_pend;
      end
   end
endmodule : cp0h_pend
`default_nettype wire

// [tb/tb_cp0h_hazard.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cp0h_regs.svh"
module tb_cp0h_hazard;
   // ==========================================
   // design under test
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic sys_ce = 1'b1;
   logic issue_valid = 1'b0;
   cp0h_pkg::cp0h_issue_s issue = '0;
   logic int_req = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h00000000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic issue_ready;
   logic fetch_uncached;
   logic fetch_kernel;
   logic int_take;
   logic ret_valid;
   logic [31:0] reg_rdata;
   logic [31:0] ret_pc;
   int error_cnt = 0;
   int tests_run = 0;

   always #25 sys_clk = ~sys_clk;

   cp0h_hazard i_dut (.sys_clk(sys_clk), .sys_ce(sys_ce), .resetn(resetn), .issue_valid(issue_valid),
      .issue(issue), .issue_ready(issue_ready), .int_req(int_req), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .fetch_uncached(fetch_uncached), .fetch_kernel(fetch_kernel), .int_take(int_take),
      .ret_valid(ret_valid), .ret_pc(ret_pc));

   // ==========================================
   // access tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t got=%08h exp=%08h", $time, got, exp);
      end
   endtask : chk

   // one slot, then an idle cycle so no signal is driven twice in a time step
   task automatic slot(input logic wr, input logic rd, input logic iv, input cp0h_pkg::cp0h_op_e op,
                       input logic [7:0] addr, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      reg_wr <= wr;
      reg_rd <= rd;
      issue_valid <= iv;
      reg_addr <= addr;
      reg_wdata <= d;
      issue <= '{op: op, data: d};
      @(negedge sys_clk);
      while (iv && issue_ready !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      if (iv) chk(n, 0);
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      issue_valid <= 1'b0;
      @(negedge sys_clk);
   endtask : slot

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      slot(1'b1, 1'b0, 1'b0, cp0h_pkg::CP0H_OP_ALU, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      slot(1'b0, 1'b1, 1'b0, cp0h_pkg::CP0H_OP_ALU, a, 32'h00000000);
      chk(reg_rdata, exp);
   endtask : rd

   task automatic op(input cp0h_pkg::cp0h_op_e o, input logic [31:0] d);
      slot(1'b0, 1'b0, 1'b1, o, 8'h00, d);
   endtask : op

   task automatic alus(input int n);
      repeat (n) op(cp0h_pkg::CP0H_OP_ALU, 32'h00000000);
   endtask : alus

   // stall length measured in cycles of issue_ready low after the branch
   task automatic stall_len(input logic [31:0] exp);
      int s;
      s = 0;
      while (issue_ready !== 1'b1 && s < 10) begin
         s++;
         @(negedge sys_clk);
      end
      chk(s, exp);
   endtask : stall_len

   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   // ==========================================
   // watchdog, far beyond the fewer than two hundred cycles the tests need
   initial begin
      #200us;
      error_cnt++;
      report_and_stop();
   end

   // ==========================================
   // tests
   initial begin
      repeat (10) @(posedge sys_clk);
      chk({28'h0, fetch_kernel, fetch_uncached, ret_valid, int_take}, 32'h00000008);
      chk(reg_rdata, 32'h00000000);
      chk(ret_pc, 32'h00000000);
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      rd(`CP0H_ADDR_STATUS, `CP0H_ST_RST);
      rd(`CP0H_ADDR_CONFIG, `CP0H_CFG_RST);
      rd(`CP0H_ADDR_INDEX, `CP0H_ZERO_RST);
      rd(`CP0H_ADDR_EPC, `CP0H_ZERO_RST);
      wr(8'h10, 32'hFFFFFFFF);
      rd(8'h10, 32'h00000000);
      // a strobe with the clock enable low must leave config alone
      @(posedge sys_clk);
      sys_ce <= 1'b0;
      wr(`CP0H_ADDR_CONFIG, {29'h0, `CP0H_K0_UNCACHED});
      @(posedge sys_clk);
      sys_ce <= 1'b1;
      rd(`CP0H_ADDR_CONFIG, `CP0H_CFG_RST);
      wr(`CP0H_ADDR_CONFIG, {29'h0, `CP0H_K0_UNCACHED});
      alus(1);
      chk(fetch_uncached, 1'b0);
      alus(1);
      chk(fetch_uncached, 1'b0);
      alus(1);
      chk(fetch_uncached, 1'b1);
      wr(`CP0H_ADDR_CONFIG, `CP0H_CFG_RST);
      alus(3);
      chk(fetch_uncached, 1'b0);
      wr(`CP0H_ADDR_EPC, 32'h00001234);
      alus(1);
      rd(`CP0H_ADDR_EPC, 32'h00001234);
      op(cp0h_pkg::CP0H_OP_PROBE, 32'h00000005);
      alus(2);
      rd(`CP0H_ADDR_INDEX, 32'h00000005);
      op(cp0h_pkg::CP0H_OP_PROBE, 32'h00000007);
      alus(1);
      rd(`CP0H_ADDR_INDEX, 32'h00000005);
      rd(`CP0H_ADDR_INDEX, 32'h00000007);
      wr(`CP0H_ADDR_EPC, 32'h00000080);
      alus(2);
      op(cp0h_pkg::CP0H_OP_EXCEPTION_RETURN, 32'h00000000);
      chk(ret_valid, 1'b1);
      chk(ret_pc, 32'h00000080);
      @(negedge sys_clk);
      chk(ret_valid, 1'b0);
      // return right after the write still sees the old saved pc
      wr(`CP0H_ADDR_EPC, 32'h00000100);
      op(cp0h_pkg::CP0H_OP_EXCEPTION_RETURN, 32'h00000000);
      chk(ret_pc, 32'h00000080);
      @(posedge sys_clk);
      int_req <= 1'b1;
      wr(`CP0H_ADDR_STATUS, 32'h00000001);
      alus(1);
      chk(int_take, 1'b0);
      alus(2);
      chk(int_take, 1'b1);
      wr(`CP0H_ADDR_STATUS, 32'h00000000);
      alus(3);
      chk(int_take, 1'b0);
      // user privilege with exception level: short window in the new mode
      wr(`CP0H_ADDR_STATUS, 32'h00000012);
      alus(1);
      chk(fetch_kernel, 1'b0);
      alus(4);
      chk(fetch_kernel, 1'b1);
      wr(`CP0H_ADDR_STATUS, 32'h00000000);
      alus(3);
      wr(`CP0H_ADDR_STATUS, 32'h00000002);
      alus(3);
      wr(`CP0H_ADDR_STATUS, 32'h00000012);
      alus(1);
      chk(fetch_kernel, 1'b1);
      wr(`CP0H_ADDR_CONFIG, {29'h0, `CP0H_K0_UNCACHED});
      op(cp0h_pkg::CP0H_OP_EXC, 32'h00000099);
      alus(1);
      chk(fetch_uncached, 1'b1);
      rd(`CP0H_ADDR_EPC, 32'h00000099);
      op(cp0h_pkg::CP0H_OP_BRANCH, 32'h00000000);
      stall_len(32'h00000000);
      op(cp0h_pkg::CP0H_OP_SHUT_I, 32'h00000000);
      op(cp0h_pkg::CP0H_OP_BRANCH, 32'h00000000);
      stall_len({28'h0, `CP0H_BR_STALL});
      alus(2);
      slot(1'b0, 1'b1, 1'b0, cp0h_pkg::CP0H_OP_ALU, `CP0H_ADDR_STATUS, 32'h00000000);
      chk(reg_rdata[`CP0H_ST_TS], 1'b1);
      report_and_stop();
   end
endmodule : tb_cp0h_hazard
`default_nettype wire
